// ===== verilog/mecr_pkg.sv
/*
 mecr_pkg: register offsets, reset values, field positions, timing counts
 and the decoded-configuration struct of the motion-event configuration bank.
 assumes: 8-bit register port, 25 MHz clock.
*/
package mecr_pkg;
    localparam int unsigned CLK_HZ = 25000000;

    // register offsets
    localparam logic [7:0] OFS_FALL_HYST  = 8'h24;
    localparam logic [7:0] OFS_MOT_DUR    = 8'h27;
    localparam logic [7:0] OFS_MOT_LVL    = 8'h28;
    localparam logic [7:0] OFS_KNOCK_TIM  = 8'h2A;
    localparam logic [7:0] OFS_KNOCK_LVL  = 8'h2B;
    localparam logic [7:0] OFS_ATT_HYST   = 8'h2C;
    localparam logic [7:0] OFS_FLAT_GATE  = 8'h2D;
    localparam logic [7:0] OFS_PED_CLR    = 8'h2E;
    localparam logic [7:0] OFS_PED_EN     = 8'h33;
    localparam logic [7:0] OFS_BIG_STEPS  = 8'h34;

    // reset values
    localparam logic [7:0] RST_FALL_HYST  = 8'h01;
    localparam logic [7:0] RST_MOT_DUR    = 8'h00;
    localparam logic [7:0] RST_MOT_LVL    = 8'h14;
    localparam logic [7:0] RST_KNOCK_TIM  = 8'h04;
    localparam logic [7:0] RST_KNOCK_LVL  = 8'h0A;
    localparam logic [7:0] RST_ATT_HYST   = 8'h18;
    localparam logic [7:0] RST_FLAT_GATE  = 8'h88;
    localparam logic [7:0] RST_PED_CLR    = 8'h00;
    localparam logic [7:0] RST_PED_EN     = 8'h22;
    localparam logic [7:0] RST_BIG_STEPS  = 8'h00;

    // field positions
    localparam int unsigned FALL_MODE_BIT   = 2;
    localparam int unsigned KNOCK_QUIET_BIT = 7;
    localparam int unsigned KNOCK_SHOCK_BIT = 6;
    localparam int unsigned PED_CLR_BIT     = 7;
    localparam int unsigned PED_EN_BIT      = 7;

    // scale steps in micro-g
    localparam int unsigned FALL_HYST_UG   = 125000;
    localparam int unsigned ATT_HYST_UG    = 62500;
    localparam int unsigned INCLINE_UG     = 32000;
    localparam int unsigned ZBLOCK_UG      = 62500;
    // motion level K in micro-g per range code 00..11
    localparam int unsigned MOT_K_UG [4]   = '{3910, 7810, 15625, 31250};
    localparam int unsigned KNOCK_K_UG [4] = '{62500, 125000, 250000, 500000};

    // knock times in ms and their cycle counts (exact multiples of ms)
    localparam int unsigned QUIET0_MS = 30;
    localparam int unsigned QUIET1_MS = 20;
    localparam int unsigned SHOCK0_MS = 50;
    localparam int unsigned SHOCK1_MS = 70;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned WIN_MS [8] = '{50, 100, 150, 200, 250, 375, 500, 700};
    // incline stable time in sample intervals per code
    localparam int unsigned INCL_T [4] = '{32, 96, 160, 224};

    typedef enum logic [1:0] {FALL_SINGLE, FALL_SUM} mecr_fall_type;
    typedef enum logic [1:0] {ATT_SYM, ATT_HIGH_ASYM, ATT_LOW_ASYM} mecr_att_type;
    typedef enum logic [1:0] {GATE_NONE, GATE_Z, GATE_Z_SLOPE} mecr_gate_type;
    typedef enum logic [1:0] {SRC_OVERSAMPLED, SRC_UNFILTERED, SRC_FILTERED} mecr_src_type;

    typedef struct packed {
        mecr_fall_type fallMode;
        logic [31:0]   fallHystUg;
        logic [4:0]    inactivePeriods;
        logic [4:0]    activePeriods;
        logic [31:0]   motionLevelUg;
        logic [31:0]   quietCycles;
        logic [31:0]   shockCycles;
        logic [31:0]   windowCycles;
        logic [7:0]    inclineStablePeriods;
        logic [31:0]   knockLevelUg;
        logic [31:0]   attHystUg;
        mecr_gate_type attGate;
        mecr_att_type  attMode;
        logic [31:0]   inclineLevelUg;
        logic [31:0]   zBlockUg;
        logic          stepEnable;
        logic [7:0]    bigMotionStepCount;
        mecr_src_type  sampleSource;
    } mecr_cfg_type;
endpackage : mecr_pkg

// ===== verilog/mecr_motion_event_config_regs.sv
/*
 mecr_motion_event_config_regs: register bank holding the motion-event
 detector settings, decoded into physical units and cycle counts, plus the
 step counter clear/enable control.
 assumes: the serial port front end delivers one-cycle write/read strobes
 with an 8-bit address on this clock; range and source select come from
 other registers of the device.
*/
// Function
// - free-fall per axis when mode bit 2 is 0, summed when 1
// - free-fall hysteresis is two-bit field times 125 mg
// - inactivity must last upper nibble plus one sample intervals
// - activity must last lower nibble plus one sample intervals
// - activity threshold is 8-bit value times range-dependent K mg
// - tap quiet time 30 ms when bit 7 clear, 20 ms set
// - tap shock time 50 ms when bit 6 clear, 70 ms set
// - second-shock window from 3-bit code, 50 to 700 ms
// - tilt stable time from bits 6:5 of the tap threshold register: 32, 96, 160, 224 intervals
// - tap threshold is 5-bit field times range-dependent K mg
// - orientation hysteresis is bits 6:4 times 62.5 mg
// - orientation blocking: none, z, or z-or-slope above 0.2 g
// - orientation mode: symmetrical, high- or low-asymmetrical from bits 1:0
// - tilt threshold upper nibble times 32 mg, 0 to 480 mg
// - z blocking level lower nibble times 62.5 mg, up to 0.9375 g
// - writing 1 to clear bit 7 returns step counter to zero
// - step detection runs only while enable bit 7 is 1
// - sample interval source: oversampled, unfiltered, or filtered data
`timescale 1ns/10ps
module mecr_motion_event_config_regs
    import mecr_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         regWrite,
    input  wire logic         regRead,
    input  wire logic [7:0]   regAddr,
    input  wire logic [7:0]   regWrData,
    input  wire logic [1:0]   fullScaleRange,
    input  wire logic [1:0]   interruptSource,
    input  wire logic         stepDetected,
    output logic [7:0]        regRdData,
    output logic              regHit,
    output logic [15:0]       stepCount,
    output mecr_cfg_type      cfg
);
    logic [7:0]  fallHyst_r;
    logic [7:0]  motDur_r;
    logic [7:0]  motLvl_r;
    logic [7:0]  knockTim_r;
    logic [7:0]  knockLvl_r;
    logic [7:0]  attHyst_r;
    logic [7:0]  flatGate_r;
    logic [7:0]  pedEn_r;
    logic [7:0]  bigSteps_r;
    logic [15:0] stepCount_r;
    logic [15:0] stepCount_nxt;
    logic [7:0]  rdData_r;
    logic [7:0]  rdData_nxt;

    function automatic logic [31:0] msToCycles(input int unsigned ms);
        msToCycles = 32'(ms * CYC_PER_MS);
    endfunction : msToCycles

    // address decode
    wire selFall   = regAddr == OFS_FALL_HYST;
    wire selDur    = regAddr == OFS_MOT_DUR;
    wire selLvl    = regAddr == OFS_MOT_LVL;
    wire selKTim   = regAddr == OFS_KNOCK_TIM;
    wire selKLvl   = regAddr == OFS_KNOCK_LVL;
    wire selAtt    = regAddr == OFS_ATT_HYST;
    wire selGate   = regAddr == OFS_FLAT_GATE;
    wire selClr    = regAddr == OFS_PED_CLR;
    wire selPedEn  = regAddr == OFS_PED_EN;
    wire selBig    = regAddr == OFS_BIG_STEPS;
    wire anySel    = selFall | selDur | selLvl | selKTim | selKLvl | selAtt
                   | selGate | selClr | selPedEn | selBig;

    wire stepClear = regWrite & selClr & regWrData[PED_CLR_BIT];
    wire stepCountEn = pedEn_r[PED_EN_BIT] & stepDetected;

    // clear wins over a coincident step: the host asked for zero
    assign stepCount_nxt = stepClear   ? 16'h0000 :
                           stepCountEn ? 16'(stepCount_r + 16'h0001) :
                                         stepCount_r;

    // clear register reads back zero since its bit is not stored
    assign rdData_nxt = selFall  ? fallHyst_r :
                        selDur   ? motDur_r   :
                        selLvl   ? motLvl_r   :
                        selKTim  ? knockTim_r :
                        selKLvl  ? knockLvl_r :
                        selAtt   ? attHyst_r  :
                        selGate  ? flatGate_r :
                        selPedEn ? pedEn_r    :
                        selBig   ? bigSteps_r : 8'h00;

    always_ff @(posedge clock) begin
        if (reset) begin
            fallHyst_r <= RST_FALL_HYST;
            motDur_r   <= RST_MOT_DUR;
            motLvl_r   <= RST_MOT_LVL;
            knockTim_r <= RST_KNOCK_TIM;
            knockLvl_r <= RST_KNOCK_LVL;
            attHyst_r  <= RST_ATT_HYST;
            flatGate_r <= RST_FLAT_GATE;
            pedEn_r    <= RST_PED_EN;
            bigSteps_r <= RST_BIG_STEPS;
        end else if (regWrite) begin
            if (selFall)  fallHyst_r <= regWrData;
            if (selDur)   motDur_r   <= regWrData;
            if (selLvl)   motLvl_r   <= regWrData;
            if (selKTim)  knockTim_r <= regWrData;
            if (selKLvl)  knockLvl_r <= regWrData;
            if (selAtt)   attHyst_r  <= regWrData;
            if (selGate)  flatGate_r <= regWrData;
            if (selPedEn) pedEn_r    <= regWrData;
            if (selBig)   bigSteps_r <= regWrData;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stepCount_r <= 16'h0000;
            rdData_r    <= 8'h00;
        end else begin
            stepCount_r <= stepCount_nxt;
            if (regRead) rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign regHit    = anySel;
    assign stepCount = stepCount_r;

    // field decode into physical units
    wire [1:0] incCode = knockLvl_r[6:5];
    wire [1:0] gateRaw = attHyst_r[3:2];
    wire [1:0] modeRaw = attHyst_r[1:0];

    always_comb begin
        cfg.fallMode = knockFallMode(fallHyst_r[FALL_MODE_BIT]);
        cfg.fallHystUg = 32'(fallHyst_r[1:0]) * FALL_HYST_UG;
        cfg.inactivePeriods = {1'b0, motDur_r[7:4]} + 5'h01;
        cfg.activePeriods = {1'b0, motDur_r[3:0]} + 5'h01;
        cfg.motionLevelUg = 32'(motLvl_r) * MOT_K_UG[fullScaleRange];
        cfg.quietCycles = msToCycles(knockTim_r[KNOCK_QUIET_BIT] ? QUIET1_MS : QUIET0_MS);
        cfg.shockCycles = msToCycles(knockTim_r[KNOCK_SHOCK_BIT] ? SHOCK1_MS : SHOCK0_MS);
        cfg.windowCycles = msToCycles(WIN_MS[knockTim_r[2:0]]);
        // garbled code: bit 7 ignored, bits 6:5 pick ascending step
        cfg.inclineStablePeriods = 8'(INCL_T[incCode]);
        cfg.knockLevelUg = 32'(knockLvl_r[4:0]) * KNOCK_K_UG[fullScaleRange];
        cfg.attHystUg = 32'(attHyst_r[6:4]) * ATT_HYST_UG;
        // blocking decode, 11 folds to none
        case (gateRaw)
            2'h1:    cfg.attGate = GATE_Z;
            2'h2:    cfg.attGate = GATE_Z_SLOPE;
            default: cfg.attGate = GATE_NONE;
        endcase
        // mode decode, 11 folds to symmetrical
        case (modeRaw)
            2'h1:    cfg.attMode = ATT_HIGH_ASYM;
            2'h2:    cfg.attMode = ATT_LOW_ASYM;
            default: cfg.attMode = ATT_SYM;
        endcase
        cfg.inclineLevelUg = 32'(flatGate_r[7:4]) * INCLINE_UG;
        cfg.zBlockUg = 32'(flatGate_r[3:0]) * ZBLOCK_UG;
        cfg.stepEnable = pedEn_r[PED_EN_BIT];
        cfg.bigMotionStepCount = bigSteps_r;
        case (interruptSource)
            2'h0:    cfg.sampleSource = SRC_OVERSAMPLED;
            2'h1:    cfg.sampleSource = SRC_UNFILTERED;
            default: cfg.sampleSource = SRC_FILTERED;
        endcase
    end

    function automatic mecr_fall_type knockFallMode(input logic b);
        knockFallMode = b ? FALL_SUM : FALL_SINGLE;
    endfunction : knockFallMode
endmodule : mecr_motion_event_config_regs

// ===== dv/mecr_assertions.sv
/*
 mecr_assertions: port checks of the motion-event config bank.
 assumes: bound to mecr_motion_event_config_regs, single clock.
*/
`timescale 1ns/10ps
module mecr_assertions
    import mecr_pkg::*;
(
    input wire logic         clock,
    input wire logic         reset,
    input wire logic         regWrite,
    input wire logic         regRead,
    input wire logic [7:0]   regAddr,
    input wire logic [7:0]   regWrData,
    input wire logic [1:0]   fullScaleRange,
    input wire logic [1:0]   interruptSource,
    input wire logic         stepDetected,
    input wire logic [7:0]   regRdData,
    input wire logic         regHit,
    input wire logic [15:0]  stepCount,
    input wire mecr_cfg_type cfg
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic clr = regWrite && regAddr == 8'h2E && regWrData[7];
    wire logic inc = stepDetected && cfg.stepEnable && !clr;
    step_clear_a: assert property (clr |=> stepCount == 16'h0000)
        else $error("no clear");
    step_count_a: assert property (inc |=> stepCount == $past(stepCount) + 16'h0001)
        else $error("no count");
    step_hold_a: assert property (!inc && !clr |=> $stable(stepCount))
        else $error("count moved");
    fall_cfg_a: assert property (regWrite && regAddr == 8'h24 |=>
        cfg.fallMode == ($past(regWrData[2]) ? FALL_SUM : FALL_SINGLE)
        && cfg.fallHystUg == $past(regWrData[1:0]) * 125000) else $error("fall cfg");
    dur_cfg_a: assert property (regWrite && regAddr == 8'h27 |=>
        cfg.inactivePeriods == $past(regWrData[7:4]) + 5'h01
        && cfg.activePeriods == $past(regWrData[3:0]) + 5'h01) else $error("durations");
    motion_lvl_a: assert property (regWrite && regAddr == 8'h28 |=>
        cfg.motionLevelUg == $past(regWrData) * MOT_K_UG[fullScaleRange]) else $error("level");
    knock_time_a: assert property (regWrite && regAddr == 8'h2A |=>
        cfg.quietCycles == ($past(regWrData[7]) ? 20 : 30) * 25000
        && cfg.shockCycles == ($past(regWrData[6]) ? 70 : 50) * 25000
        && cfg.windowCycles == WIN_MS[$past(regWrData[2:0])] * 25000) else $error("knock");
    rd_refuse_a: assert property (regRead && (!regHit || regAddr == 8'h2E)
        |=> regRdData == 8'h00) else $error("refused read");
    hit_decode_a: assert property (regHit == (regAddr inside {8'h24, 8'h27, 8'h28,
        8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h33, 8'h34})) else $error("hit decode");
    att_cfg_a: assert property (regWrite && regAddr == 8'h2C |=>
        cfg.attHystUg == $past(regWrData[6:4]) * 62500
        && cfg.attGate == ($past(regWrData[3:2]) == 2'h1 ? GATE_Z :
                           $past(regWrData[3:2]) == 2'h2 ? GATE_Z_SLOPE : GATE_NONE)
        && cfg.attMode == ($past(regWrData[1:0]) == 2'h1 ? ATT_HIGH_ASYM :
                           $past(regWrData[1:0]) == 2'h2 ? ATT_LOW_ASYM : ATT_SYM))
        else $error("attitude cfg");
    flat_gate_a: assert property (regWrite && regAddr == 8'h2D |=>
        cfg.inclineLevelUg == $past(regWrData[7:4]) * 32000
        && cfg.zBlockUg == $past(regWrData[3:0]) * 62500) else $error("gate cfg");
endmodule : mecr_assertions

bind mecr_motion_event_config_regs mecr_assertions i_chk (.clock(clock), .reset(reset),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .fullScaleRange(fullScaleRange), .interruptSource(interruptSource),
    .stepDetected(stepDetected), .regRdData(regRdData), .regHit(regHit),
    .stepCount(stepCount), .cfg(cfg));

// ===== dv/mecr_host_model.sv
/*
 mecr_host_model: host side of the register port.
 assumes: tasks entered 1 ns after a rising edge; each takes one cycle.
*/
`timescale 1ns/10ps
module mecr_host_model (
    input  wire logic  clock,
    output logic       regWrite,
    output logic       regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        regWrite = w;
        regRead = r;
        regAddr = a;
        regWrData = d;
        @(posedge clock);
        #1;
    endtask : op
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask : wr
    // idle bus keeps moving so stale values never look valid
    task automatic idle;
        op(1'b0, 1'b0, ~regAddr, ~regWrData);
    endtask : idle
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
endmodule : mecr_host_model

// ===== dv/mecr_motion_event_config_regs_tb_top.sv
/*
 mecr_motion_event_config_regs_tb_top: self-checking bench of the config bank.
 assumes: host model drives the register port, checker bound to the design.
*/
`timescale 1ns/10ps
module mecr_motion_event_config_regs_tb_top
    import mecr_pkg::*;
;
    logic         clock, reset, regWrite, regRead, stepDetected, regHit, rdSeen;
    logic [7:0]   regAddr, regWrData, regRdData, d;
    logic [1:0]   fullScaleRange, interruptSource;
    logic [15:0]  stepCount;
    mecr_cfg_type cfg;
    int           err_total, comparisons, seed;
    logic [7:0]   expQ[$];
    logic [7:0]   ofs[10] = '{8'h24, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h33, 8'h34};
    logic [7:0]   rst[10] = '{8'h01, 8'h00, 8'h14, 8'h04, 8'h0A, 8'h18, 8'h88, 8'h00, 8'h22, 8'h00};
    mecr_motion_event_config_regs i_dut (.clock(clock), .reset(reset), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .fullScaleRange(fullScaleRange), .interruptSource(interruptSource),
        .stepDetected(stepDetected), .regRdData(regRdData), .regHit(regHit),
        .stepCount(stepCount), .cfg(cfg));
    mecr_host_model i_host (.clock(clock), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s %0h not %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // expected read noted here, compared when the data shows
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_host.op(1'b0, 1'b1, a, ~a);
    endtask : rd
    task automatic pulse(input int n);
        repeat (n) begin
            stepDetected = 1'b1;
            i_host.idle();
            stepDetected = 1'b0;
            i_host.idle();
        end
    endtask : pulse
    always @(posedge clock) begin
        if (rdSeen === 1'b1)
            chk(regRdData, expQ.pop_front(), "read");
        rdSeen <= regRead;
    end
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // generous: the tests need about 70 cycles
    initial begin
        repeat (2000) @(posedge clock);
        err_total++;
        close_out();
    end
    initial begin
        {seed, err_total, comparisons} = {32'd51, 64'd0};
        {reset, stepDetected, rdSeen, fullScaleRange, interruptSource} = 7'h40;
        repeat (12) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 10; i++)
            rd(ofs[i], rst[i]);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            d = 8'($random(seed));
            i_host.wr(ofs[i], d);
            rd(ofs[i], ofs[i] == 8'h2E ? 8'h00 : d);
        end
        // unmapped write is dropped, read gives zero
        i_host.wr(8'hFF, 8'h5A);
        rd(8'hFF, 8'h00);
        $display("test access done");
        i_host.wr(8'h33, 8'h80);
        pulse(3);
        chk(stepCount, 3, "steps");
        i_host.wr(8'h33, 8'h00);
        pulse(2);
        chk(stepCount, 3, "off steps");
        i_host.wr(8'h33, 8'h80);
        stepDetected = 1'b1;
        i_host.wr(8'h2E, 8'h80);
        stepDetected = 1'b0;
        chk(stepCount, 0, "cleared");
        $display("test steps done");
        i_host.wr(8'h28, 8'hFF);
        i_host.wr(8'h2B, 8'h7F);
        i_host.idle();
        chk(32'(cfg.inclineStablePeriods), 224, "incline time");
        for (int r = 0; r < 4; r++) begin
            {fullScaleRange, interruptSource} = {2'(r), 2'(r)};
            #1;
            chk(cfg.motionLevelUg, 255 * MOT_K_UG[r], "motion");
            chk(cfg.knockLevelUg, 31 * KNOCK_K_UG[r], "knock");
            chk(32'(cfg.sampleSource), r == 3 ? 2 : r, "source");
        end
        $display("test ranges done");
        // mid-run reset must bring the bank back to its defaults
        reset = 1'b1;
        i_host.idle();
        i_host.idle();
        reset = 1'b0;
        rd(8'h2B, 8'h0A);
        rd(8'h28, 8'h14);
        i_host.idle();
        i_host.idle();
        $display("test mid reset done");
        close_out();
    end
endmodule : mecr_motion_event_config_regs_tb_top
